// ### logic/tcc_timer.sv
// two-channel capture/compare/PWM timer with a classic Wishbone register slave
`include "tcc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module tcc_timer #(
  parameter int CHANNELS = 2
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // channel pins
  input wire logic [CHANNELS-1:0] chanPinIn,
  output logic [CHANNELS-1:0] chanPinOut,
  output logic [CHANNELS-1:0] chanPinOe,
  // interrupt requests
  output logic wrapIrq,
  output logic [CHANNELS-1:0] chanIrq
);
  // bus handshake state
  logic ack_q;
  logic [31:0] datO_q;
  logic req;
  logic wrEn;
  logic rdEn;
  logic [31:0] rdData;

  // address decode results
  logic hitTsc;
  logic hitCnt;
  logic hitMod;
  logic [CHANNELS-1:0] hitCsc;
  logic [CHANNELS-1:0] hitVal;

  // timer control and status
  logic wrapFlag_q;
  logic wrapArm_q;
  logic wrapIe_q;
  logic halt_q;
  logic [2:0] ps_q;
  logic [15:0] mod_q;
  logic [15:0] cnt_q;
  logic cntRst;
  logic psTick;
  logic ctick;
  logic wrap;

  // channel state
  tcc_pkg::tcc_chcfg_t cfg_q [CHANNELS];
  logic [CHANNELS-1:0] chIe_q;
  logic [CHANNELS-1:0] chFlag_q;
  logic [CHANNELS-1:0] chArm_q;
  logic [15:0] val_q [CHANNELS];
  logic [15:0] cmpSel [CHANNELS];
  logic [CHANNELS-1:0] evt;
  logic [CHANNELS-1:0] capEvt;
  logic [CHANNELS-1:0] chEnable;
  logic link;
  logic lastWr_q;
  logic activeSel_q;

  // bus request qualifiers: effects happen on the edge where ack is high
  always_comb begin
    req = wb_cyc_i & wb_stb_i;
    wrEn = req & wb_we_i & ack_q;
    rdEn = req & ~wb_we_i & ack_q;
  end

  // address decode
  always_comb begin
    hitTsc = 1'b0;
    hitCnt = 1'b0;
    hitMod = 1'b0;
    hitCsc = '0;
    hitVal = '0;
    if (wb_adr_i == `TCC_OFS_TSC) begin
      hitTsc = 1'b1;
    end else if (wb_adr_i == `TCC_OFS_CNT) begin
      hitCnt = 1'b1;
    end else if (wb_adr_i == `TCC_OFS_MOD) begin
      hitMod = 1'b1;
    end else if (wb_adr_i == `TCC_OFS_CSC0) begin
      hitCsc[0] = 1'b1;
    end else if (wb_adr_i == `TCC_OFS_VAL0) begin
      hitVal[0] = 1'b1;
    end else if (wb_adr_i == `TCC_OFS_CSC1) begin
      hitCsc[1] = 1'b1;
    end else if (wb_adr_i == `TCC_OFS_VAL1) begin
      hitVal[1] = 1'b1;
    end
  end

  // read data mux; unmapped addresses read zero
  always_comb begin
    rdData = 32'h0000_0000;
    if (hitTsc) begin
      rdData[`TCC_TSC_FLAG] = wrapFlag_q;
      rdData[`TCC_TSC_IE] = wrapIe_q;
      rdData[`TCC_TSC_HALT] = halt_q;
      rdData[`TCC_TSC_PS_HI:`TCC_TSC_PS_LO] = ps_q;
    end else if (hitCnt) begin
      rdData[15:0] = cnt_q;
    end else if (hitMod) begin
      rdData[15:0] = mod_q;
    end else if (hitCsc[0]) begin
      rdData[7:0] = {chFlag_q[0], chIe_q[0], cfg_q[0]};
    end else if (hitVal[0]) begin
      rdData[15:0] = val_q[0];
    end else if (hitCsc[1] && !link) begin
      rdData[7:0] = {chFlag_q[1], chIe_q[1], cfg_q[1]};
    end else if (hitVal[1]) begin
      rdData[15:0] = val_q[1];
    end
  end

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // read data captured as ack rises, reads only so it holds across writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      datO_q <= 32'h0000_0000;
    end else if (req && !ack_q && !wb_we_i) begin
      datO_q <= rdData;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = datO_q;

  // counter reset strobe from the control register
  assign cntRst = wrEn & hitTsc & wb_sel_i[0] & wb_dat_i[`TCC_TSC_CRST];

  // prescaler for the counter clock
  tcc_prescaler #(
    .DIV_W(`TCC_PS_DIV_W)
  ) u_prescaler (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(cntRst),
    .sel(ps_q),
    .tick(psTick)
  );

  // counter clock and wrap event
  always_comb begin
    ctick = psTick & ~halt_q;
    wrap = ctick & (cnt_q == mod_q);
  end

  // timer control fields
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrapIe_q <= 1'b0;
      halt_q <= `TCC_HALT_RST;
      ps_q <= `TCC_PS_RST;
    end else if (wrEn && hitTsc && wb_sel_i[0]) begin
      wrapIe_q <= wb_dat_i[`TCC_TSC_IE];
      halt_q <= wb_dat_i[`TCC_TSC_HALT];
      ps_q <= wb_dat_i[`TCC_TSC_PS_HI:`TCC_TSC_PS_LO];
    end
  end

  // modulo register, byte lanes honoured; all ones means free running
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mod_q <= `TCC_MOD_RST;
    end else if (wrEn && hitMod) begin
      if (wb_sel_i[0]) begin
        mod_q[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        mod_q[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // shared up-counter; a modulo below the count rolls through all ones to zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
    end else if (cntRst) begin
      cnt_q <= 16'h0000;
    end else if (wrap) begin
      cnt_q <= 16'h0000;
    end else if (ctick) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // wrap flag: two-step clear, a new wrap wins and disarms the clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrapFlag_q <= 1'b0;
      wrapArm_q <= 1'b0;
    end else if (wrap) begin
      wrapFlag_q <= 1'b1;
      wrapArm_q <= 1'b0;
    end else if (rdEn && hitTsc) begin
      wrapArm_q <= datO_q[`TCC_TSC_FLAG];
    end else if (wrEn && hitTsc && wb_sel_i[0]) begin
      if (wrapArm_q && !wb_dat_i[`TCC_TSC_FLAG]) begin
        wrapFlag_q <= 1'b0;
      end
      wrapArm_q <= 1'b0;
    end
  end

  assign wrapIrq = wrapFlag_q & wrapIe_q;

  // buffered link: channel 0 mode bit couples both channels
  assign link = cfg_q[0].msB;

  // buffered pair tracking: last written pair takes over at each wrap
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lastWr_q <= 1'b0;
      activeSel_q <= 1'b0;
    end else begin
      if (wrEn && hitVal[0]) begin
        lastWr_q <= 1'b0;
      end else if (wrEn && hitVal[1]) begin
        lastWr_q <= 1'b1;
      end
      if (!link) begin
        activeSel_q <= 1'b0;
        lastWr_q <= 1'b0;
      end else if (wrap) begin
        activeSel_q <= lastWr_q;
      end
    end
  end

  // compare value seen by each channel engine
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      cmpSel[i] = val_q[i];
      chEnable[i] = 1'b1;
    end
    if (link) begin
      cmpSel[0] = activeSel_q ? val_q[1] : val_q[0];
      chEnable[1] = 1'b0;
    end
  end

  // per-channel registers and engines
  for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
    tcc_chan_if chIf ();

    assign chIf.cfg = cfg_q[g];
    assign chIf.enable = chEnable[g];
    assign chIf.cmpVal = cmpSel[g];
    assign chIf.count = cnt_q;
    assign chIf.tick = ctick;
    assign chIf.wrap = wrap;
    assign evt[g] = chIf.evt;
    assign capEvt[g] = chIf.capEvt;
    assign chanPinOut[g] = chIf.pinOut;
    assign chanPinOe[g] = chIf.pinOe;
    assign chanIrq[g] = chFlag_q[g] & chIe_q[g];

    tcc_channel u_chan (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .pinIn(chanPinIn[g]),
      .bus(chIf.chan)
    );

    // channel configuration; only channel 0 carries the link bit
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        cfg_q[g] <= '0;
        chIe_q[g] <= 1'b0;
      end else if (wrEn && hitCsc[g] && wb_sel_i[0] && !(g == 1 && link)) begin
        cfg_q[g] <= tcc_pkg::tcc_chcfg_t'(wb_dat_i[`TCC_CSC_CFG_HI:`TCC_CSC_CFG_LO]);
        chIe_q[g] <= wb_dat_i[`TCC_CSC_IE];
        if (g != 0) begin
          cfg_q[g].msB <= 1'b0;
        end
      end
    end

    // channel flag: set wins over the two-step clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        chFlag_q[g] <= 1'b0;
        chArm_q[g] <= 1'b0;
      end else if (evt[g]) begin
        chFlag_q[g] <= 1'b1;
        chArm_q[g] <= 1'b0;
      end else if (rdEn && hitCsc[g]) begin
        chArm_q[g] <= datO_q[`TCC_CSC_FLAG];
      end else if (wrEn && hitCsc[g] && wb_sel_i[0]) begin
        if (chArm_q[g] && !wb_dat_i[`TCC_CSC_FLAG]) begin
          chFlag_q[g] <= 1'b0;
        end
        chArm_q[g] <= 1'b0;
      end
    end

    // value register, not reset; capture beats a bus write
    always_ff @(posedge ref_clk) begin
      if (capEvt[g]) begin
        val_q[g] <= cnt_q;
      end else if (wrEn && hitVal[g]) begin
        if (wb_sel_i[0]) begin
          val_q[g][7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          val_q[g][15:8] <= wb_dat_i[15:8];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### logic/tcc_defines.svh
// register offsets, field positions, reset values and timing figures of the timer
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH
// byte offsets of the word registers
`define TCC_OFS_TSC 8'h00
`define TCC_OFS_CNT 8'h04
`define TCC_OFS_MOD 8'h08
`define TCC_OFS_CSC0 8'h0C
`define TCC_OFS_VAL0 8'h10
`define TCC_OFS_CSC1 8'h14
`define TCC_OFS_VAL1 8'h18
// timer status and control fields
`define TCC_TSC_FLAG 7
`define TCC_TSC_IE 6
`define TCC_TSC_HALT 5
`define TCC_TSC_CRST 4
`define TCC_TSC_PS_HI 2
`define TCC_TSC_PS_LO 0
// channel status and control fields
`define TCC_CSC_FLAG 7
`define TCC_CSC_IE 6
`define TCC_CSC_CFG_HI 5
`define TCC_CSC_CFG_LO 0
// reset values
`define TCC_MOD_RST 16'hFFFF
`define TCC_PS_RST 3'h0
`define TCC_HALT_RST 1'b0
// prescaler: seven rates, divide by 2**select, top code folds onto the slowest rate
`define TCC_PS_DIV_W 6
`define TCC_PS_TOP 3'h6
// input pin synchroniser depth in bus clocks
`define TCC_SYNC_STAGES 2
`endif

// ### logic/tcc_pkg.sv
// types shared by the timer modules
package tcc_pkg;
  // compare action or capture edge code
  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_CLEAR = 2'b10,
    ACT_SET = 2'b11
  } tcc_act_t;
  // channel configuration, laid out as the low bits of a channel control register
  typedef struct packed {
    logic msB;
    logic msA;
    tcc_act_t els;
    logic tov;
    logic full;
  } tcc_chcfg_t;
endpackage

// ### logic/tcc_chan_if.sv
// link between the timer core and one channel engine
`timescale 1ns/10ps
`default_nettype none
interface tcc_chan_if;
  tcc_pkg::tcc_chcfg_t cfg;
  logic enable;
  logic [15:0] cmpVal;
  logic [15:0] count;
  logic tick;
  logic wrap;
  logic evt;
  logic capEvt;
  logic pinOut;
  logic pinOe;
  modport core (output cfg, enable, cmpVal, count, tick, wrap, input evt, capEvt, pinOut, pinOe);
  modport chan (input cfg, enable, cmpVal, count, tick, wrap, output evt, capEvt, pinOut, pinOe);
endinterface
`default_nettype wire

// ### logic/tcc_prescaler.sv
// bus clock prescaler giving seven counter clock rates
`include "tcc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module tcc_prescaler #(
  parameter int DIV_W = `TCC_PS_DIV_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // control
  input wire logic clear,
  input wire logic [2:0] sel,
  // one-cycle counter clock enable
  output logic tick
);
  logic [DIV_W-1:0] div_q;
  logic [2:0] selClamp;
  logic [DIV_W-1:0] mask;

  // free divider, restarted by the counter reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
    end else if (clear) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // select zero gives every bus clock, each step up to six halves the rate
  always_comb begin
    selClamp = (sel > `TCC_PS_TOP) ? `TCC_PS_TOP : sel;
    mask = DIV_W'((1 << selClamp) - 1);
    tick = ((div_q & mask) == mask);
  end
endmodule
`default_nettype wire

// ### logic/tcc_channel.sv
// one capture/compare channel engine: pin sync, edge detect, compare match, pin level
`timescale 1ns/10ps
`default_nettype none
module tcc_channel (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // channel pin input
  input wire logic pinIn,
  // core side
  tcc_chan_if.chan bus
);
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic pin_q;
  logic rise;
  logic fall;
  logic capMode;
  logic cmpMode;
  logic match;

  // two-stage pin synchroniser plus an edge history stage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      sync1_q <= pinIn;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // mode decode and event detection
  always_comb begin
    rise = sync2_q & ~prev_q;
    fall = ~sync2_q & prev_q;
    capMode = bus.enable & ~bus.cfg.msB & ~bus.cfg.msA & (bus.cfg.els != tcc_pkg::ACT_NONE);
    cmpMode = bus.enable & (bus.cfg.msB | bus.cfg.msA) & (bus.cfg.els != tcc_pkg::ACT_NONE);
    bus.capEvt = capMode & ((bus.cfg.els[0] & rise) | (bus.cfg.els[1] & fall));
    // match as the counter steps onto the value, so a pulse lasts exactly value ticks
    match = cmpMode & bus.tick & ((bus.wrap ? 16'h0000 : bus.count + 16'h0001) == bus.cmpVal);
    bus.evt = bus.capEvt | match;
  end

  // output level: preset, wrap toggle ahead of compare action
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 1'b1;
    end else if (!cmpMode) begin
      pin_q <= ~bus.cfg.msA;
    end else if (bus.wrap && bus.cfg.tov) begin
      pin_q <= bus.cfg.full ? 1'b1 : ~pin_q;
    end else if (bus.cfg.full && bus.cfg.tov) begin
      pin_q <= 1'b1;
    end else if (match) begin
      case (bus.cfg.els)
        tcc_pkg::ACT_TOGGLE: pin_q <= ~pin_q;
        tcc_pkg::ACT_CLEAR: pin_q <= 1'b0;
        tcc_pkg::ACT_SET: pin_q <= 1'b1;
        default: pin_q <= pin_q;
      endcase
    end
  end

  assign bus.pinOut = pin_q;
  assign bus.pinOe = cmpMode;
endmodule
`default_nettype wire

// ### verif/tcc_pin_model.sv
// stand-in for the external circuits on the two timer channel pins
`timescale 1ns/10ps
`default_nettype none
module tcc_pin_model (
  // timer side of the pins
  input wire logic [1:0] pinOut,
  input wire logic [1:0] pinOe,
  // level seen back at the pin inputs
  output logic [1:0] pinIn
);
  logic [1:0] drv = 2'b00;
  // wire level: the timer wins where it drives, else the outside source
  assign pinIn = (pinOe & pinOut) | (~pinOe & drv);
  // outside edge, applied on the caller's clock edge
  task automatic drive(input int ch, input logic lvl);
    drv[ch] <= lvl;
  endtask
endmodule
`default_nettype wire

// ### verif/tcc_timer_monitor.sv
// port-level assertions and covers for the timer
`include "tcc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module tcc_timer_monitor #(
  parameter int CHANNELS = 2
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // channel pins
  input wire logic [CHANNELS-1:0] chanPinIn,
  input wire logic [CHANNELS-1:0] chanPinOut,
  input wire logic [CHANNELS-1:0] chanPinOe,
  // interrupt requests
  input wire logic wrapIrq,
  input wire logic [CHANNELS-1:0] chanIrq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // bus handshake
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked in one cycle");
  a_ack_needs_req: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_data_on_read: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("read data moved outside a read");
  // register widths and holes
  a_count_width: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `TCC_OFS_CNT |->
    wb_dat_o[31:16] == 16'h0000)
    else $error("counter wider than 16 bits");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > `TCC_OFS_VAL1 |->
    wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  // requests drop and pin drive changes only through register writes
  a_wrap_irq_clear: assert property ($fell(wrapIrq) |-> $past(wb_ack_o && wb_we_i))
    else $error("wrap request dropped without a write");
  a_chan_irq_clear: assert property (|($past(chanIrq) & ~chanIrq) |-> $past(wb_ack_o && wb_we_i))
    else $error("channel request dropped without a write");
  a_oe_by_config: assert property ($changed(chanPinOe) |-> $past(wb_ack_o && wb_we_i))
    else $error("pin drive changed without a write");
  // main scenarios
  c_wrap_irq: cover property ($rose(wrapIrq));
  c_capture: cover property ($rose(chanIrq[1]));
  c_pwm_edge: cover property (chanPinOe[0] && $rose(chanPinOut[0]));
endmodule
bind tcc_timer tcc_timer_monitor #(.CHANNELS(CHANNELS)) mon_i (.ref_clk(ref_clk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chanPinIn(chanPinIn),
  .chanPinOut(chanPinOut), .chanPinOe(chanPinOe), .wrapIrq(wrapIrq), .chanIrq(chanIrq));
`default_nettype wire

// ### verif/tcc_timer_tb.sv
// self-checking bench for the two-channel timer
`include "tcc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module tcc_timer_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, q, c1;
  logic ack, wrapIrq;
  logic [1:0] pinIn, pinOut, pinOe, chanIrq;
  int bad_count = 0;
  int checks = 0;
  int n, nh, nl;
  // 10 MHz bus clock
  always #50 ref_clk = ~ref_clk;
  tcc_timer tcc_timer_i (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .chanPinIn(pinIn),
    .chanPinOut(pinOut), .chanPinOe(pinOe), .wrapIrq(wrapIrq), .chanIrq(chanIrq));
  tcc_pin_model tcc_pin_model_i (.pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn));
  // one classic bus cycle, read data left in q
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int g;
    g = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge ref_clk);
    while (ack !== 1'b1 && g < 50) begin
      @(posedge ref_clk);
      g++;
    end
    if (g == 50) bad_count++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk);
  endtask
  // word and bit comparisons
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  // one full high run then the following low run of channel 0's pin
  task automatic period;
    nh = 0;
    nl = 0;
    n = 0;
    while (pinOut[0] !== 1'b0 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    while (pinOut[0] !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    while (pinOut[0] === 1'b1 && nh < 2000) begin
      @(posedge ref_clk);
      nh++;
    end
    while (pinOut[0] === 1'b0 && nl < 2000) begin
      @(posedge ref_clk);
      nl++;
    end
  endtask
  // cycles of 300 in which channel 0's pin is off the given level
  task automatic hold(input logic lvl);
    n = 0;
    repeat (300) begin
      @(posedge ref_clk);
      if (pinOut[0] !== lvl) n++;
    end
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // guard against a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    print_verdict();
  end
  // test sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rchk(`TCC_OFS_TSC, 32'h0000_0000);
    rchk(`TCC_OFS_MOD, 32'h0000_FFFF);
    rchk(8'h1C, 32'h0000_0000);
    // short modulo, wrap flag and its clearing
    wb(1'b1, `TCC_OFS_MOD, 32'h0000_0010);
    wb(1'b1, `TCC_OFS_TSC, 32'h0000_0050);
    n = 0;
    while (wrapIrq !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      n++;
    end
    chkb(wrapIrq, 1'b1);
    wb(1'b1, `TCC_OFS_TSC, 32'h0000_0060);
    rchk(`TCC_OFS_TSC, 32'h0000_00E0);
    wb(1'b0, `TCC_OFS_CNT, 32'h0000_0000);
    chkb(q <= 32'h0000_0010, 1'b1);
    wb(1'b1, `TCC_OFS_TSC, 32'h0000_0060);
    chkb(wrapIrq, 1'b0);
    // every prescale code: ten ticks in ten divided periods
    wb(1'b1, `TCC_OFS_MOD, 32'h0000_FFFF);
    for (int ps = 0; ps < 8; ps++) begin
      wb(1'b1, `TCC_OFS_TSC, 32'h0000_0010 | ps);
      wb(1'b0, `TCC_OFS_CNT, 32'h0000_0000);
      c1 = q;
      repeat ((10 << ((ps == 7) ? 6 : ps)) - 3) @(posedge ref_clk);
      wb(1'b0, `TCC_OFS_CNT, 32'h0000_0000);
      chk(q - c1, 32'h0000_000A);
    end
    // rising-edge capture on channel 1, falling edge ignored
    wb(1'b1, `TCC_OFS_TSC, 32'h0000_0010);
    wb(1'b1, `TCC_OFS_CSC1, 32'h0000_0044);
    tcc_pin_model_i.drive(1, 1'b1);
    repeat (20) @(posedge ref_clk);
    tcc_pin_model_i.drive(1, 1'b0);
    repeat (20) @(posedge ref_clk);
    wb(1'b0, `TCC_OFS_VAL1, 32'h0000_0000);
    c1 = q;
    rchk(`TCC_OFS_CSC1, 32'h0000_00C4);
    repeat (34) @(posedge ref_clk);
    tcc_pin_model_i.drive(1, 1'b1);
    repeat (10) @(posedge ref_clk);
    wb(1'b0, `TCC_OFS_VAL1, 32'h0000_0000);
    chk({16'h0000, q[15:0] - c1[15:0]}, 32'h0000_0050);
    rchk(`TCC_OFS_CSC1, 32'h0000_00C4);
    wb(1'b1, `TCC_OFS_CSC1, 32'h0000_0044);
    chkb(chanIrq[1], 1'b0);
    // unbuffered pwm, 256-clock period
    wb(1'b1, `TCC_OFS_MOD, 32'h0000_00FF);
    wb(1'b1, `TCC_OFS_VAL0, 32'h0000_0080);
    wb(1'b1, `TCC_OFS_CSC0, 32'h0000_001A);
    wb(1'b1, `TCC_OFS_TSC, 32'h0000_0010);
    chkb(pinOe[0], 1'b1);
    period();
    chk(nh, 32'd128);
    chk(nh + nl, 32'd256);
    // larger value just after a wrap, smaller one just after a compare
    wb(1'b1, `TCC_OFS_VAL0, 32'h0000_00C0);
    period();
    chk(nh, 32'd192);
    while (pinOut[0] !== 1'b0) @(posedge ref_clk);
    wb(1'b1, `TCC_OFS_VAL0, 32'h0000_0080);
    period();
    chk(nh, 32'd128);
    wb(1'b1, `TCC_OFS_CSC0, 32'h0000_001B);
    hold(1'b1);
    chk(n, 32'd0);
    wb(1'b1, `TCC_OFS_CSC0, 32'h0000_0018);
    repeat (300) @(posedge ref_clk);
    hold(1'b0);
    chk(n, 32'd0);
    wb(1'b1, `TCC_OFS_CSC0, 32'h0000_001E);
    period();
    chk(nl, 32'd128);
    // buffered pair on channel 0's pin
    wb(1'b1, `TCC_OFS_CSC1, 32'h0000_0018);
    chkb(pinOe[1], 1'b1);
    wb(1'b1, `TCC_OFS_VAL0, 32'h0000_0040);
    wb(1'b1, `TCC_OFS_CSC0, 32'h0000_002A);
    wb(1'b1, `TCC_OFS_TSC, 32'h0000_0010);
    period();
    chk(nh, 32'd64);
    chkb(pinOe[1], 1'b0);
    rchk(`TCC_OFS_CSC1, 32'h0000_0000);
    wb(1'b1, `TCC_OFS_VAL1, 32'h0000_00C0);
    repeat (300) @(posedge ref_clk);
    period();
    chk(nh, 32'd192);
    print_verdict();
  end
endmodule
`default_nettype wire
